// ==== core/sdsq_chan.sv ====
// Per-channel permanent diagnostic: restart checking, overload recheck and diagnostic cycle.
`timescale 1ns/1ns
module sdsq_chan #(
  parameter int CHECK_CYCLES = sdsq_pkg::CHECK_CYC,
  parameter int DIAG_CYCLES = sdsq_pkg::DIAG_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic diag_mode,
  input wire logic rearm,
  input wire logic ovl,
  input wire logic [4:0] flt,
  output logic chan_off,
  output logic res_valid,
  output logic [3:0] res
);
  import sdsq_pkg::*;

  sdsq_chan_type state;
  logic [31:0] cnt;
  logic [4:0] acc;
  logic armed;

  assign chan_off = (state != CH_OK);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= CH_OK;
      cnt <= 32'h0;
      acc <= 5'h0;
      res_valid <= 1'b0;
      res <= 4'h0;
    end
    else
    begin
      res_valid <= 1'b0;
      cnt <= cnt + 32'h1;
      if (!run)
      begin
        state <= CH_OK;
      end
      else
      begin
        unique case (state)
          CH_OK:
          begin
            cnt <= 32'h0;
            if (ovl)
            begin
              state <= (diag_mode && armed) ? CH_CHECK : CH_RESTART; // R08 R09
            end
          end
          CH_CHECK:
          begin
            if (cnt == 32'(CHECK_CYCLES - 1))
            begin
              cnt <= 32'h0;
              acc <= 5'h0f;
              state <= ovl ? CH_DIAG : CH_OK; // R10
            end
          end
          CH_DIAG:
          begin
            acc <= acc & {1'b0, flt[3:0]}; // R07 R19
            if (cnt == 32'(DIAG_CYCLES - 1))
            begin
              cnt <= 32'h0;
              res <= sdsq_rank(acc & {1'b0, flt[3:0]}); // R18
              res_valid <= 1'b1;
              state <= CH_RESTART; // R11
            end
          end
          CH_RESTART:
          begin
            if (cnt == 32'(CHECK_CYCLES - 1))
            begin
              cnt <= 32'h0;
              if (!ovl)
              begin
                state <= CH_OK; // R08
              end
            end
          end
        endcase
      end
    end
  end

  // A finished cycle disarms until the next result read; the read wins a tie.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      armed <= 1'b1;
    end
    else if (rearm)
    begin
      armed <= 1'b1; // R20
    end
    else if (state == CH_DIAG && cnt == 32'(DIAG_CYCLES - 1))
    begin
      armed <= 1'b0; // R11
    end
  end
endmodule : sdsq_chan

// ==== core/sdsq_pkg.sv ====
// Constants, types and fault ranking shared by the output diagnostic sequencer.
package sdsq_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int CHECK_TIME_MS = 1;
  localparam int ACQ_TIME_MS = 100;
  localparam int DIAG_TIME_MS = 100;
  localparam int CHECK_CYC = CHECK_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int ACQ_CYC = ACQ_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int DIAG_CYC = DIAG_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [1:0] MIN_PEAKS = 2'h3;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL1 = 8'h00;
  localparam logic [7:0] OFS_CTRL2 = 8'h04;
  localparam logic [7:0] OFS_RESULT = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;

  // ==========================================================================
  // Control fields and reset values
  localparam int C1_DIAG = 6;
  localparam int C1_OFFSET = 5;
  localparam int C1_GAIN_F = 4;
  localparam int C1_GAIN_R = 3;
  localparam int C1_UNMUTE_F = 2;
  localparam int C1_UNMUTE_R = 1;
  localparam int C1_CLIP = 0;
  localparam int C2_RUN = 4;
  localparam int C2_LINE = 3;
  localparam int C2_AC = 2;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [7:0] CTRL1_MASK = 8'h7f;
  localparam logic [7:0] CTRL2_MASK = 8'h1c;

  // ==========================================================================
  // Result byte fields, one byte per channel
  localparam int R_SGND = 0;
  localparam int R_SVS = 1;
  localparam int R_OPEN = 2;
  localparam int R_SHORT = 3;
  localparam int R_PERM = 4;
  localparam int R_TWEET = 5;
  localparam int R_DONE = 6;

  // ==========================================================================
  // State types
  typedef enum logic [1:0] {
    ST_STBY = 2'b00,
    ST_PULSE = 2'b01,
    ST_RUN = 2'b11
  } sdsq_state_type;

  typedef enum logic [1:0] {
    CH_OK = 2'b00,
    CH_CHECK = 2'b01,
    CH_DIAG = 2'b11,
    CH_RESTART = 2'b10
  } sdsq_chan_type;

  // Fault inputs {open, across, supply, gnd_sink, gnd_source}; answer {short, open, supply, gnd}.
  function automatic logic [3:0] sdsq_rank(input logic [4:0] f);
    logic [3:0] r;
    r = 4'h0;
    if (f[2])
    begin
      r = {2'b00, 1'b1, f[0]};
    end
    else if (f[0])
    begin
      r = 4'h1;
    end
    else if (f[1])
    begin
      r = f[4] ? 4'h4 : 4'h1;
    end
    else if (f[3])
    begin
      r = 4'h8;
    end
    else if (f[4])
    begin
      r = 4'h4;
    end
    return r;
  endfunction : sdsq_rank

endpackage : sdsq_pkg

// ==== core/sdsq_sync.sv ====
// Three-stage input synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ns
module sdsq_sync #(
  parameter int WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      dout <= '0;
    end
    else
    begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      dout <= (s2 & s3) | (dout & (s2 ^ s3));
    end
  end
endmodule : sdsq_sync

// ==== core/sdsq_top.sv ====
// Output diagnostic sequencer: APB registers, turn-on test pulse, offset and AC checks.
// Notes on behaviour
// R01: Leaving stand-by with diagnostics enabled runs the turn-on load test.
// R02: Turn-on result is held; a new pulse needs a result read first.
// R03: Test pulse runs first while the stage stays in stand-by, outputs high-Z.
// R04: When biased, permanent checks run; turn-on result stays until a short.
// R05: Output status is latched at the end of the pulse, about 100 ms.
// R06: Only short-across and open thresholds follow line-driver selection.
// R07: Permanent checks see shorts, never open load.
// R08: Without diagnostics, a shorted channel is off and rechecked every 1 ms.
// R09: Diagnostic mode is enabled by software and starts on overload.
// R10: Recheck after 1 ms; clear resumes, persistent overload starts 100 ms cycle.
// R11: After a cycle the channel restarts; next cycle armed only by a read.
// R12: With offset detection on, DC offset beyond 2 V is flagged.
// R13: Offset window runs from last read or enable to this read.
// R14: Overload during a window cancels offset and AC results.
// R15: Fewer than 3 peak pulses between enable and read flags open tweeter.
// R16: Host supplies a test tone of at least 3 cycles.
// R17: Multiple faults show one at a time across read and repair.
// R18: Double faults are reported by fixed priority.
// R19: A fault is reported only if stable for the whole period.
// R20: Every read re-arms all cycles and returns the previous results; a read on the last turn-on pulse cycle leaves the pulse disarmed.
// R21: Host waits 500 ms before unmute and 20 ms before stand-by.
// R22: Host reads 200 ms after enable, or 30 ms after offset enable.
// R23: Diagnostic enable bit set enables, cleared defeats diagnostics.
// R24: Stand-by bit set leaves stand-by, cleared enters it.
// R25: Results change only at cycle end and are sampled at read setup.
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
module sdsq_top #(
  parameter int CHANNELS = 4,
  parameter int CHECK_CYCLES = sdsq_pkg::CHECK_CYC,
  parameter int ACQ_CYCLES = sdsq_pkg::ACQ_CYC,
  parameter int DIAG_CYCLES = sdsq_pkg::DIAG_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [CHANNELS-1:0] pin_gnd_source,
  input wire logic [CHANNELS-1:0] pin_gnd_sink,
  input wire logic [CHANNELS-1:0] pin_supply,
  input wire logic [CHANNELS-1:0] pin_across,
  input wire logic [CHANNELS-1:0] pin_open,
  input wire logic [CHANNELS-1:0] pin_overload,
  input wire logic [CHANNELS-1:0] pin_offset,
  input wire logic [CHANNELS-1:0] pin_peak,
  output logic stage_standby,
  output logic out_hiz,
  output logic test_pulse,
  output logic [CHANNELS-1:0] chan_off,
  output logic [CHANNELS-1:0] line_thr,
  output logic [CHANNELS-1:0] gain_low,
  output logic unmute_front,
  output logic unmute_rear,
  output logic clip_level_high
);
  import sdsq_pkg::*;

  // ==========================================================================
  // Input synchronisers
  logic [CHANNELS-1:0] s_so;
  logic [CHANNELS-1:0] s_sink;
  logic [CHANNELS-1:0] s_vs;
  logic [CHANNELS-1:0] s_acr;
  logic [CHANNELS-1:0] s_open;
  logic [CHANNELS-1:0] s_ovl;
  logic [CHANNELS-1:0] s_off;
  logic [CHANNELS-1:0] s_peak;
  logic [CHANNELS-1:0] peak_d;

  sdsq_sync #(
    .WIDTH(8 * CHANNELS)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din({pin_gnd_source, pin_gnd_sink, pin_supply, pin_across,
          pin_open, pin_overload, pin_offset, pin_peak}),
    .dout({s_so, s_sink, s_vs, s_acr, s_open, s_ovl, s_off, s_peak})
  );

  // ==========================================================================
  // APB slave
  function automatic logic addr_ok(input logic [7:0] a);
    return (a == OFS_CTRL1) || (a == OFS_CTRL2) || (a == OFS_RESULT) || (a == OFS_STATUS);
  endfunction : addr_ok

  logic [7:0] ctrl1;
  logic [7:0] ctrl2;
  logic wr;
  logic rd_res;
  logic wr_c1;
  logic wr_c2;
  logic off_start;
  logic ac_start;
  logic ton_armed;
  sdsq_state_type state;
  logic [31:0] cnt;
  logic [CHANNELS-1:0][7:0] held;
  logic [CHANNELS-1:0] off_flag;
  logic [CHANNELS-1:0] tw_flag;
  logic [31:0] result_word;
  logic [31:0] status_word;

  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok(paddr);
  assign wr = psel && penable && pwrite && addr_ok(paddr);
  assign wr_c1 = wr && (paddr == OFS_CTRL1);
  assign wr_c2 = wr && (paddr == OFS_CTRL2);
  assign rd_res = psel && penable && !pwrite && (paddr == OFS_RESULT);
  assign off_start = wr_c1 && pwdata[C1_OFFSET] && !ctrl1[C1_OFFSET];
  assign ac_start = wr_c2 && pwdata[C2_AC] && !ctrl2[C2_AC];

  always_comb
  begin
    result_word = 32'h0;
    for (int i = 0; i < CHANNELS && i < 4; i++)
    begin
      result_word[8*i +: 8] = held[i] | {2'b00, tw_flag[i], 2'b00, off_flag[i], 2'b00};
    end
  end

  assign status_word = {24'h0, 3'h0, ctrl2[C2_AC], ctrl1[C1_OFFSET], ton_armed, state};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl1 <= CTRL1_RST;
      ctrl2 <= CTRL2_RST;
    end
    else
    begin
      if (wr_c1)
      begin
        ctrl1 <= pwdata[7:0] & CTRL1_MASK; // R23
      end
      if (wr_c2)
      begin
        ctrl2 <= pwdata[7:0] & CTRL2_MASK; // R24
      end
    end
  end

  // Read data is captured in the setup cycle, so the access sees a stable snapshot.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0;
    end
    else if (psel && !penable && !pwrite)
    begin
      unique case (paddr)
        OFS_CTRL1: prdata <= {24'h0, ctrl1};
        OFS_CTRL2: prdata <= {24'h0, ctrl2};
        OFS_RESULT: prdata <= result_word; // R25 R20
        OFS_STATUS: prdata <= status_word;
        default: prdata <= 32'h0;
      endcase
    end
  end

  // ==========================================================================
  // Turn-on sequencing
  logic [CHANNELS-1:0][4:0] ton_acc;
  logic ton_done;

  assign ton_done = (state == ST_PULSE) && (cnt == 32'(ACQ_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= ST_STBY;
      cnt <= 32'h0;
    end
    else
    begin
      cnt <= cnt + 32'h1;
      unique case (state)
        ST_STBY:
        begin
          cnt <= 32'h0;
          if (ctrl2[C2_RUN])
          begin
            state <= (ctrl1[C1_DIAG] && ton_armed) ? ST_PULSE : ST_RUN; // R01 R02 R03
          end
        end
        ST_PULSE:
        begin
          if (!ctrl2[C2_RUN])
          begin
            state <= ST_STBY;
          end
          else if (ton_done)
          begin
            state <= ST_RUN; // R04 R05
          end
        end
        ST_RUN:
        begin
          cnt <= 32'h0;
          if (!ctrl2[C2_RUN])
          begin
            state <= ST_STBY;
          end
        end
      endcase
    end
  end

  // Only a result read re-arms; a new pulse before then would hide an unread result.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ton_armed <= 1'b1;
    end
    else if (ton_done)
    begin
      ton_armed <= 1'b0; // R02
    end
    else if (rd_res)
    begin
      ton_armed <= 1'b1; // R20
    end
  end

  assign stage_standby = (state != ST_RUN); // R03
  assign out_hiz = (state != ST_RUN);
  assign test_pulse = (state == ST_PULSE);
  assign unmute_front = ctrl1[C1_UNMUTE_F];
  assign unmute_rear = ctrl1[C1_UNMUTE_R];
  assign clip_level_high = ctrl1[C1_CLIP];

  // ==========================================================================
  // Per-channel logic
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++)
    begin : g_ch
      logic front;
      logic [4:0] live;
      logic perm_valid;
      logic [3:0] perm_res;
      logic off_acc;
      logic off_dis;
      logic ac_dis;
      logic [1:0] peaks;

      assign front = (g % 2) == 0;
      assign live = {s_open[g], s_acr[g], s_vs[g], s_sink[g], s_so[g]};
      assign gain_low[g] = front ? ctrl1[C1_GAIN_F] : ctrl1[C1_GAIN_R];
      assign line_thr[g] = gain_low[g] && ctrl2[C2_LINE]; // R06

      sdsq_chan #(
        .CHECK_CYCLES(CHECK_CYCLES),
        .DIAG_CYCLES(DIAG_CYCLES)
      ) u_chan (
        .pclk(pclk),
        .presetn(presetn),
        .run(state == ST_RUN),
        .diag_mode(ctrl1[C1_DIAG]),
        .rearm(rd_res),
        .ovl(s_ovl[g]),
        .flt(live),
        .chan_off(chan_off[g]),
        .res_valid(perm_valid),
        .res(perm_res)
      );

      // The pulse samples each fault across its whole top; a flicker drops it.
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          ton_acc[g] <= 5'h00;
        end
        else if (state != ST_PULSE)
        begin
          ton_acc[g] <= 5'h1f;
        end
        else
        begin
          ton_acc[g] <= ton_acc[g] & live; // R19
        end
      end

      // Held result: changes only when a cycle ends; done clears on read, set wins.
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          held[g] <= 8'h00;
        end
        else
        begin
          if (rd_res)
          begin
            held[g][R_DONE] <= 1'b0; // R20
          end
          if (ton_done)
          begin
            held[g] <= {1'b0, 1'b1, 2'b00, sdsq_rank(ton_acc[g] & live)}; // R05 R17 R18
          end
          else if (perm_valid)
          begin
            held[g] <= {1'b0, 1'b1, 1'b0, 1'b1, perm_res}; // R04 R11 R25
          end
        end
      end

      // Offset window: opens at enable or read, closes at the next read.
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          off_acc <= 1'b0;
          off_dis <= 1'b0;
          off_flag[g] <= 1'b0;
        end
        else
        begin
          if (rd_res)
          begin
            off_flag[g] <= ctrl1[C1_OFFSET] && off_acc && s_off[g] && !off_dis; // R12 R14
          end
          if (rd_res || off_start)
          begin
            off_acc <= 1'b1; // R13
            off_dis <= 1'b0;
          end
          else
          begin
            off_acc <= off_acc && s_off[g]; // R19
            off_dis <= off_dis || s_ovl[g]; // R14
          end
        end
      end

      // AC check counts rising edges of the peak comparator, saturating at the minimum.
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          peak_d[g] <= 1'b0;
          peaks <= 2'h0;
          ac_dis <= 1'b0;
          tw_flag[g] <= 1'b0;
        end
        else
        begin
          peak_d[g] <= s_peak[g];
          if (rd_res)
          begin
            tw_flag[g] <= ctrl2[C2_AC] && !ac_dis && (peaks < MIN_PEAKS); // R15 R14
          end
          if (rd_res || ac_start)
          begin
            peaks <= 2'h0;
            ac_dis <= 1'b0;
          end
          else
          begin
            if (s_peak[g] && !peak_d[g] && peaks != MIN_PEAKS)
            begin
              peaks <= peaks + 2'h1; // R15 R16
            end
            ac_dis <= ac_dis || s_ovl[g]; // R14
          end
        end
      end
    end
  endgenerate

endmodule : sdsq_top

// ==== verif/sdsq_checker.sv ====
// Port-level assertions for the output diagnostic sequencer.
`timescale 1ns/1ns
module sdsq_checker
  import sdsq_pkg::*;
#(
  parameter int CHANNELS = 4,
  parameter int ACQ_CYCLES = sdsq_pkg::ACQ_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic stage_standby,
  input wire logic out_hiz,
  input wire logic test_pulse,
  input wire logic [CHANNELS-1:0] line_thr,
  input wire logic [CHANNELS-1:0] gain_low
);
  // ==========================================================================
  // Helpers
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic unmapped;
  logic [31:0] pulse_cnt;
  assign unmapped = !(paddr inside {OFS_CTRL1, OFS_CTRL2, OFS_RESULT, OFS_STATUS});
  // Counts high cycles of the test pulse, since its length is far beyond a repetition.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pulse_cnt <= 32'h0;
    else if (test_pulse)
      pulse_cnt <= pulse_cnt + 32'h1;
    else
      pulse_cnt <= 32'h0;
  end
  // ==========================================================================
  // Assertions
  pready_high_a: assert property (pready)
    else $error("pready low");
  slverr_map_a: assert property (pslverr == (psel && penable && unmapped))
    else $error("pslverr does not match an unmapped access");
  unmapped_zero_a: assert property (psel && !penable && !pwrite && unmapped |=> prdata == 32'h0)
    else $error("unmapped read data not zero");
  ctrl_mask_a: assert property (psel && !penable && !pwrite && paddr == OFS_CTRL1
    |=> prdata[31:7] == 25'h0)
    else $error("control read shows bits outside its mask");
  hiz_follows_a: assert property (out_hiz == stage_standby)
    else $error("output high impedance differs from stand-by");
  pulse_stby_a: assert property (test_pulse |-> stage_standby && $past(stage_standby))
    else $error("test pulse while power stage biased");
  pulse_len_a: assert property ($fell(test_pulse) |-> pulse_cnt == ACQ_CYCLES)
    else $error("test pulse length wrong");
  line_gain_a: assert property ((line_thr & ~gain_low) == '0)
    else $error("line thresholds without low gain");
  gain_write_a: assert property (psel && penable && pwrite && paddr == OFS_CTRL1
    |=> gain_low[0] == $past(pwdata[C1_GAIN_F]) && gain_low[1] == $past(pwdata[C1_GAIN_R]))
    else $error("gain did not follow control write");
  gain_pair_a: assert property (gain_low[0] == gain_low[2] && gain_low[1] == gain_low[3])
    else $error("front or rear pair gains differ");
  standby_enter_a: assert property (psel && penable && pwrite && paddr == OFS_CTRL2
    && !pwdata[C2_RUN] |-> ##[1:2] stage_standby)
    else $error("stand-by not entered after run cleared");
endmodule : sdsq_checker

bind sdsq_top sdsq_checker #(.CHANNELS(CHANNELS), .ACQ_CYCLES(ACQ_CYCLES)) sdsq_checker_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .stage_standby(stage_standby), .out_hiz(out_hiz), .test_pulse(test_pulse),
  .line_thr(line_thr), .gain_low(gain_low));

// ==== verif/sdsq_load_model.sv ====
// Speaker load and test tone model producing peak current pulses.
`timescale 1ns/1ns
module sdsq_load_model (
  input wire logic link_clk,
  input wire logic tone_on,
  input wire logic [3:0] tweeter_ok,
  output logic [3:0] pin_peak
);
  // ==========================================================================
  // Peaks
  // One peak per tone cycle where a tweeter is fitted; no tone leaves the sensor low.
  assign pin_peak = (tone_on && link_clk) ? tweeter_ok : 4'h0;
endmodule : sdsq_load_model

// ==== verif/tb.sv ====
// Self-checking bench for the output diagnostic sequencer.
`timescale 1ns/1ns
module tb;
  import sdsq_pkg::*;
  // ==========================================================================
  // Signals
  localparam int CHK = 20;
  localparam int DG = 50;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, stage_standby, out_hiz, test_pulse;
  logic unmute_front, unmute_rear, clip_level_high;
  logic [3:0] f_gso = 4'h0, f_gsk = 4'h0, f_sup = 4'h0, f_acr = 4'h0, f_opn = 4'h0;
  logic [3:0] f_ovl = 4'h0, f_ofs = 4'h0, tweeter_ok = 4'hf, pin_peak, chan_off, line_thr;
  logic link_clk = 1'b0, tone_on = 1'b0;
  int fail_count = 0, total_checks = 0;
  always #50 pclk = ~pclk;
  initial
  begin
    #137;
    forever #400 if (tone_on) link_clk = ~link_clk;
  end
  sdsq_top #(.CHECK_CYCLES(CHK), .ACQ_CYCLES(50), .DIAG_CYCLES(DG)) sdsq_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_gnd_source(f_gso), .pin_gnd_sink(f_gsk), .pin_supply(f_sup), .pin_across(f_acr),
    .pin_open(f_opn), .pin_overload(f_ovl), .pin_offset(f_ofs), .pin_peak(pin_peak),
    .stage_standby(stage_standby), .out_hiz(out_hiz), .test_pulse(test_pulse),
    .chan_off(chan_off), .line_thr(line_thr), .gain_low(), .unmute_front(unmute_front),
    .unmute_rear(unmute_rear), .clip_level_high(clip_level_high));
  sdsq_load_model sdsq_load_model_i (.link_clk(link_clk), .tone_on(tone_on),
    .tweeter_ok(tweeter_ok), .pin_peak(pin_peak));
  // ==========================================================================
  // Tasks
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task apb(input int wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= 1'(wr);
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : cyc
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report
  initial
  begin
    #2000000;
    fail_count++;
    final_report;
  end
  // ==========================================================================
  // Tests
  initial
  begin
    int i;
    cyc(10);
    presetn <= 1'b1;
    cyc(5);
    apb(0, OFS_CTRL1, 0); check("ctrl1 reset", rd, {24'h0, CTRL1_RST});
    apb(0, OFS_CTRL2, 0); check("ctrl2 reset", rd, {24'h0, CTRL2_RST});
    apb(0, OFS_STATUS, 0); check("status reset", rd, 32'h4);
    apb(1, OFS_CTRL1, 32'hff); apb(1, OFS_CTRL2, 32'hef); cyc(1);
    check("line thr", {28'h0, line_thr}, 32'hf);
    apb(0, OFS_CTRL1, 0); check("ctrl1 mask", rd, 32'h7f);
    apb(0, OFS_CTRL2, 0); check("ctrl2 mask", rd, 32'h0c);
    apb(1, 8'h10, 32'hff); check("bad write err", {31'h0, err}, 32'h1);
    apb(0, 8'h10, 0); check("bad read", {rd[30:0], err}, 32'h1);
    // Double faults on three channels, one clean channel.
    f_gso <= 4'h5; f_acr <= 4'h1; f_sup <= 4'h4; f_gsk <= 4'h8; f_opn <= 4'h8;
    apb(1, OFS_CTRL1, 32'h40); apb(1, OFS_CTRL2, 32'h0); cyc(5);
    apb(1, OFS_CTRL2, 32'h10); cyc(2);
    check("pulse", {29'h0, test_pulse, stage_standby, out_hiz}, 32'h7);
    for (i = 0; i < 200 && test_pulse === 1'b1; i++) cyc(1);
    cyc(2);
    apb(0, OFS_STATUS, 0); check("run state", rd & 32'h3, 32'h3);
    apb(0, OFS_RESULT, 0); check("turn-on", rd, 32'h44434041);
    f_gso <= 4'h0; f_acr <= 4'h0; f_sup <= 4'h0; f_gsk <= 4'h0; f_opn <= 4'h0;
    apb(0, OFS_RESULT, 0); check("done clear", rd & 32'h40404040, 32'h0);
    // A spike shorter than the recheck delay.
    f_ovl <= 4'h1; cyc(5); f_ovl <= 4'h0; cyc(CHK + 20);
    check("resume", {28'h0, chan_off}, 32'h0);
    apb(0, OFS_RESULT, 0); check("no cycle", rd & 32'h50, 32'h0);
    f_ovl <= 4'h1; f_acr <= 4'h1; cyc(CHK + DG + 30);
    check("restart", {28'h0, chan_off}, 32'h1);
    apb(0, OFS_RESULT, 0); check("perm", rd & 32'hff, 32'h58);
    f_ovl <= 4'h0; f_acr <= 4'h0; cyc(CHK + 20);
    check("recover", {28'h0, chan_off}, 32'h0);
    // Diagnostics defeated: plain restart on one channel.
    apb(1, OFS_CTRL1, 32'h0); f_ovl <= 4'h2; f_acr <= 4'h2; cyc(3 * CHK);
    check("alone off", {28'h0, chan_off}, 32'h2);
    f_ovl <= 4'h0; f_acr <= 4'h0; cyc(CHK + 20);
    check("restarted", {28'h0, chan_off}, 32'h0);
    apb(0, OFS_RESULT, 0); apb(0, OFS_RESULT, 0);
    check("no report", rd & 32'hff00, 32'h0);
    // Offset window: persistent, then interrupted.
    apb(1, OFS_CTRL1, 32'h60); f_ofs <= 4'h2; cyc(10);
    apb(0, OFS_RESULT, 0); cyc(30); apb(0, OFS_RESULT, 0); apb(0, OFS_RESULT, 0);
    check("offset", rd & 32'h400, 32'h400);
    cyc(10); f_ofs <= 4'h0; cyc(4); f_ofs <= 4'h2; cyc(20);
    apb(0, OFS_RESULT, 0); apb(0, OFS_RESULT, 0);
    check("offset gap", rd & 32'h400, 32'h0);
    f_ofs <= 4'h0;
    // Tone with two tweeters missing, one of them overloaded mid-window.
    tweeter_ok <= 4'h5; tone_on <= 1'b1; apb(1, OFS_CTRL2, 32'h14); cyc(10);
    apb(0, OFS_RESULT, 0); f_ovl <= 4'h8; cyc(3); f_ovl <= 4'h0; cyc(100);
    apb(0, OFS_RESULT, 0); tone_on <= 1'b0; apb(0, OFS_RESULT, 0);
    check("tweeter", rd & 32'h20202020, 32'h00002000);
    // Power down.
    apb(1, OFS_CTRL1, 32'h67); cyc(1);
    check("unmuted", {29'h0, unmute_front, unmute_rear, clip_level_high}, 32'h7);
    apb(1, OFS_CTRL1, 32'h60); cyc(20);
    check("muted", {29'h0, unmute_front, unmute_rear, clip_level_high}, 32'h0);
    apb(1, OFS_CTRL1, 32'h0); apb(1, OFS_CTRL2, 32'h0); cyc(3);
    check("standby", {31'h0, stage_standby}, 32'h1);
    apb(0, OFS_STATUS, 0); check("stby state", rd & 32'h3, 32'h0);
    final_report;
  end
endmodule : tb
